// ---- verilog/cpu_status_register.sv ----
/*
  Processor status word with AXI4-Lite access and datapath flag update.
  Assumes one clock, synchronous inputs and a well-behaved bus master.
*/
// Our own choices: the AXI4-Lite register port and the register offsets.
// Contract
// R1: Five condition flags in low byte, control fields in high system byte.
// R2: User privilege reaches only the low byte; supervisor reaches the whole word.
// R3: Trace field 00 off, 01 change of flow, 10 every instruction, 11 reserved.
// R4: Privilege bit 0 means user level, 1 means supervisor level.
// R5: Three-bit mask 0 to 7 masks interrupt requests against its level.
// R6: Extend flag loaded with the carry value by many instructions.
// R7: Negative flag set when result MSB is one.
// R8: Zero flag set when all result bits are zero.
// R9: Overflow flag set on two's complement signed overflow.
// R10: Carry flag set on carry or borrow; offered for shift chaining.
// R11: Trace 15:14, privilege 13, mask 10:8, X N Z V C at 4:0.
`timescale 1ns/1ps
`default_nettype none

module cpu_status_register (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic [psw_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [psw_pkg::ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  input wire psw_pkg::alu_result_type i_alu,
  input wire logic [2:0] i_irq_level,
  output logic o_irq_accept,
  output logic o_supervisor,
  output logic o_trace_flow,
  output logic o_trace_instr,
  output logic o_extend,
  output logic o_carry
);
  import psw_pkg::*;

  state_type st_reg;
  state_type st_next;
  logic res_msb;
  logic res_zero;

  // ****************************************
  // Status word helpers
  // ****************************************

  // Word as software sees it; system byte hidden at user level
  function automatic logic [15:0] psw_view(input psw_type p, input logic show_sys);
    logic [15:0] w;
    w = 16'h0000;
    w[POS_EXTEND] = p.x; // [R11]
    w[POS_NEG] = p.n;
    w[POS_ZERO] = p.z;
    w[POS_OVF] = p.v;
    w[POS_CARRY] = p.c;
    if (show_sys) begin // [R2]
      w[POS_TRACE+:2] = p.trace; // [R1]
      w[POS_SUPER] = p.supervisor;
      w[POS_MASK+:3] = p.mask;
    end
    return w;
  endfunction : psw_view

  // Byte-lane write, system byte only at supervisor level
  function automatic psw_type psw_write(input psw_type p, input logic [15:0] d,
                                        input logic [1:0] strb);
    psw_type q;
    q = p;
    if (strb[0]) begin // [R1]
      q.x = d[POS_EXTEND];
      q.n = d[POS_NEG];
      q.z = d[POS_ZERO];
      q.v = d[POS_OVF];
      q.c = d[POS_CARRY];
    end
    if (strb[1] && p.supervisor) begin // [R2] [R4]
      q.trace = trace_type'(d[POS_TRACE+:2]);
      q.supervisor = d[POS_SUPER];
      q.mask = d[POS_MASK+:3];
    end
    return q;
  endfunction : psw_write

  // ****************************************
  // Result sign and zero by operand size
  // ****************************************

  // Pick MSB and zero test for the operand size
  always_comb begin
    unique case (i_alu.size)
      SIZE_BYTE: begin
        res_msb = i_alu.result[7];
        res_zero = (i_alu.result[7:0] == 8'h00);
      end
      SIZE_WORD: begin
        res_msb = i_alu.result[15];
        res_zero = (i_alu.result[15:0] == 16'h0000);
      end
      default: begin
        res_msb = i_alu.result[31];
        res_zero = (i_alu.result == 32'h0000_0000);
      end
    endcase
  end

  // ****************************************
  // Next state
  // ****************************************

  // Bus channels, status word update, derived outputs
  always_comb begin
    st_next = st_reg;
    // Write address and data, either order
    if (i_awvalid && st_reg.awready) begin
      st_next.aw_have = 1'b1;
      st_next.awaddr = i_awaddr;
    end
    if (i_wvalid && st_reg.wready) begin
      st_next.w_have = 1'b1;
      st_next.wdata = i_wdata[15:0];
      st_next.wstrb = i_wstrb[1:0];
    end
    if (st_reg.bvalid && i_bready) begin
      st_next.bvalid = 1'b0;
    end
    // Commit a write once both halves are in
    if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
      st_next.aw_have = 1'b0;
      st_next.w_have = 1'b0;
      st_next.bvalid = 1'b1;
      if (st_reg.awaddr[ADDR_W-1:2] == PSW_OFFSET[ADDR_W-1:2]) begin
        st_next.bresp = RESP_OKAY;
        st_next.psw = psw_write(st_reg.psw, st_reg.wdata, st_reg.wstrb);
      end else begin
        st_next.bresp = RESP_SLVERR;
      end
    end
    // Datapath flags win over a bus write of the same cycle
    if (i_alu.update) begin
      st_next.psw.n = res_msb; // [R7]
      st_next.psw.z = res_zero; // [R8]
      st_next.psw.v = i_alu.overflow; // [R9]
      st_next.psw.c = i_alu.carry; // [R10]
      if (i_alu.x_load) begin
        st_next.psw.x = i_alu.carry; // [R6]
      end
    end
    // Read channel
    if (st_reg.rvalid && i_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (i_arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      if (i_araddr[ADDR_W-1:2] == PSW_OFFSET[ADDR_W-1:2]) begin
        st_next.rdata = {16'h0000, psw_view(st_reg.psw, st_reg.psw.supervisor)}; // [R2]
        st_next.rresp = RESP_OKAY;
      end else begin
        st_next.rdata = 32'h0000_0000;
        st_next.rresp = RESP_SLVERR;
      end
    end
    st_next.awready = !st_next.aw_have;
    st_next.wready = !st_next.w_have;
    st_next.arready = !st_next.rvalid;
    // Interrupt level must exceed the mask
    st_next.irq_accept = (i_irq_level > st_reg.psw.mask); // [R5]
    st_next.trace_flow = (st_next.psw.trace == TRACE_FLOW); // [R3]
    st_next.trace_instr = (st_next.psw.trace == TRACE_INSTR); // [R3]
  end

  // ****************************************
  // State register
  // ****************************************

  // Register all state
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      st_reg <= '0;
      st_reg.psw <= psw_type'({PSW_RESET[15:14], PSW_RESET[13], PSW_RESET[10:8], PSW_RESET[4:0]});
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from flops
  assign o_awready = st_reg.awready;
  assign o_wready = st_reg.wready;
  assign o_bvalid = st_reg.bvalid;
  assign o_bresp = st_reg.bresp;
  assign o_arready = st_reg.arready;
  assign o_rvalid = st_reg.rvalid;
  assign o_rdata = st_reg.rdata;
  assign o_rresp = st_reg.rresp;
  assign o_irq_accept = st_reg.irq_accept;
  assign o_supervisor = st_reg.psw.supervisor; // [R4]
  assign o_trace_flow = st_reg.trace_flow;
  assign o_trace_instr = st_reg.trace_instr;
  assign o_extend = st_reg.psw.x;
  assign o_carry = st_reg.psw.c; // [R10]

  // ****************************************
  // Assertions
  // ****************************************

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  // System byte frozen while at user level
  a_user_sys_frozen: assert property (!st_reg.psw.supervisor // [R2]
    |=> $stable(st_reg.psw.mask) && $stable(st_reg.psw.trace) && st_reg.psw.supervisor == 1'b0)
    else $error("system byte changed at user level");

  // User read hides the system byte
  a_user_read_mask: assert property ($rose(o_rvalid) && !$past(st_reg.psw.supervisor) // [R2]
    |-> o_rdata[15:8] == 8'h00)
    else $error("system byte visible to user read");

  // Reserved bits always read zero
  a_rsvd_read_zero: assert property ($rose(o_rvalid) // [R11]
    |-> o_rdata[7:5] == 3'h0 && o_rdata[12:11] == 2'h0 && o_rdata[31:16] == 16'h0000)
    else $error("reserved bits read nonzero");

  // Trace outputs follow the trace field
  a_trace_decode: assert property (o_trace_flow == (st_reg.psw.trace == TRACE_FLOW) // [R3]
    && o_trace_instr == (st_reg.psw.trace == TRACE_INSTR))
    else $error("trace decode mismatch");

  // Interrupt acceptance compares level to mask
  a_irq_mask: assert property (1'b1 // [R5]
    |=> o_irq_accept == ($past(i_irq_level) > $past(st_reg.psw.mask)))
    else $error("interrupt mask compare wrong");

  // Top mask lets no request through
  a_irq_top_mask: assert property (st_reg.psw.mask == 3'h7 |=> !o_irq_accept) // [R5]
    else $error("request accepted under top mask");

  // Extend copies carry when asked
  a_extend_copy: assert property (i_alu.update && i_alu.x_load // [R6]
    |=> o_extend == $past(i_alu.carry))
    else $error("extend not loaded from carry");

  // Negative and zero follow the result
  a_neg_zero: assert property (i_alu.update // [R7] [R8]
    |=> st_reg.psw.n == $past(res_msb) && st_reg.psw.z == $past(res_zero))
    else $error("negative or zero flag wrong");

  // Overflow and carry follow the datapath
  a_ovf_carry: assert property (i_alu.update // [R9] [R10]
    |=> st_reg.psw.v == $past(i_alu.overflow) && o_carry == $past(i_alu.carry))
    else $error("overflow or carry flag wrong");

  // Privilege output mirrors the state bit
  a_priv_out: assert property (o_supervisor == st_reg.psw.supervisor) // [R4]
    else $error("privilege output mismatch");

  // Word stands without an update or a write
  a_psw_hold: assert property (!i_alu.update && !(st_reg.aw_have && st_reg.w_have && !o_bvalid) // [R1]
    |=> $stable(st_reg.psw))
    else $error("status word changed without cause");

  // Supervisor write of the system byte lands
  a_super_sys_write: assert property (st_reg.aw_have && st_reg.w_have && !o_bvalid // [R2] [R4]
    && st_reg.psw.supervisor && st_reg.wstrb[1] && st_reg.awaddr[ADDR_W-1:2] == PSW_OFFSET[ADDR_W-1:2]
    |=> st_reg.psw.mask == $past(st_reg.wdata[POS_MASK+:3]) && o_supervisor == $past(st_reg.wdata[POS_SUPER]))
    else $error("system byte write lost");

  // Write answered one cycle after both halves held
  a_write_resp: assert property (st_reg.aw_have && st_reg.w_have && !o_bvalid |=> o_bvalid) // [R1]
    else $error("write response late");

  // Read answered at the edge the address is taken
  a_read_resp: assert property (i_arvalid && o_arready |=> o_rvalid) // [R1]
    else $error("read response late");

  // Write response stands until taken
  a_bresp_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp)) // [R1]
    else $error("write response dropped early");

  // Read data stands until taken
  a_rdata_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata)) // [R2]
    else $error("read data dropped early");

  // Main scenarios
  c_user_write: cover property (st_reg.aw_have && st_reg.w_have && !st_reg.psw.supervisor);
  c_super_write: cover property (st_reg.aw_have && st_reg.w_have && st_reg.psw.supervisor);
  c_flag_update: cover property (i_alu.update && i_alu.x_load);
  c_bad_read: cover property (o_rvalid && o_rresp == RESP_SLVERR);
  c_trace_rsvd: cover property (st_reg.psw.trace == TRACE_RSVD);

endmodule : cpu_status_register

`default_nettype wire

// ---- verilog/psw_pkg.sv ----
/*
  Constants and types for the processor status word block.
  Assumes a 100 MHz single clock and an AXI4-Lite register bus.
*/
`default_nettype none

package psw_pkg;

  // ****************************************
  // Bus and map
  // ****************************************
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] PSW_OFFSET = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // Field positions of the status word
  // ****************************************
  localparam int POS_TRACE = 14;
  localparam int POS_SUPER = 13;
  localparam int POS_MASK = 8;
  localparam int POS_EXTEND = 4;
  localparam int POS_NEG = 3;
  localparam int POS_ZERO = 2;
  localparam int POS_OVF = 1;
  localparam int POS_CARRY = 0;
  localparam logic [15:0] PSW_RESET = 16'h2700;

  // ****************************************
  // Encodings
  // ****************************************
  typedef enum logic [1:0] {
    TRACE_OFF = 2'h0,
    TRACE_FLOW = 2'h1,
    TRACE_INSTR = 2'h2,
    TRACE_RSVD = 2'h3
  } trace_type;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_WORD = 2'h1,
    SIZE_LONG = 2'h2
  } size_type;

  typedef struct packed {
    trace_type trace;
    logic supervisor;
    logic [2:0] mask;
    logic x;
    logic n;
    logic z;
    logic v;
    logic c;
  } psw_type;

  // Datapath result offered for a flag update
  typedef struct packed {
    logic update;
    size_type size;
    logic [31:0] result;
    logic carry;
    logic overflow;
    logic x_load;
  } alu_result_type;

  typedef struct packed {
    logic aw_have;
    logic w_have;
    logic [ADDR_W-1:0] awaddr;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    psw_type psw;
    logic irq_accept;
    logic trace_flow;
    logic trace_instr;
  } state_type;

endpackage : psw_pkg

`default_nettype wire

// ---- verif/test_cpu_status_register.sv ----
/*
  Self-checking bench for the processor status word block.
  Assumes the design package is compiled first; the bench is the AXI4-Lite master.
*/
`timescale 1ns/1ps
`default_nettype none

module test_cpu_status_register;
  import psw_pkg::*;

  logic i_mclk;
  logic i_rst;
  logic [ADDR_W-1:0] i_awaddr;
  logic [ADDR_W-1:0] i_araddr;
  logic [3:0] i_wstrb;
  logic [31:0] i_wdata;
  logic i_awvalid;
  logic i_wvalid;
  logic i_bready;
  logic i_arvalid;
  logic i_rready;
  logic [2:0] i_irq_level;
  alu_result_type i_alu;
  logic o_awready;
  logic o_wready;
  logic o_bvalid;
  logic o_arready;
  logic o_rvalid;
  logic [1:0] o_bresp;
  logic [1:0] o_rresp;
  logic [31:0] o_rdata;
  logic o_irq_accept;
  logic o_supervisor;
  logic o_trace_flow;
  logic o_trace_instr;
  logic o_extend;
  logic o_carry;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;

  // Device under test; protection inputs are ignored by it
  cpu_status_register u_cpu_status_register (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_awaddr(i_awaddr), .i_awprot(3'h0),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
    .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
    .i_bready(i_bready), .i_araddr(i_araddr), .i_arprot(3'h0), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid),
    .i_rready(i_rready), .i_alu(i_alu), .i_irq_level(i_irq_level), .o_irq_accept(o_irq_accept),
    .o_supervisor(o_supervisor), .o_trace_flow(o_trace_flow), .o_trace_instr(o_trace_instr),
    .o_extend(o_extend), .o_carry(o_carry)
  );

  // ****************************************
  // Clock, timeout and report
  // ****************************************
  initial begin
    i_mclk = 1'h0;
    forever #5 i_mclk = ~i_mclk;
  end

  // Cut a hang short
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      give_verdict();
    end
  end

  task give_verdict;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  task check_word(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %0t word %h want %h", $time, got, exp);
    end
  endtask : check_word

  task check_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %0t bit %b want %b", $time, got, exp);
    end
  endtask : check_bit

  // ****************************************
  // Bus and datapath drivers
  // ****************************************
  task axi_write(input logic [3:0] a, input logic [15:0] d, input logic [3:0] s, input logic [1:0] er);
    @(posedge i_mclk);
    i_awaddr <= a;
    i_wdata <= {16'h0, d};
    i_wstrb <= s;
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    forever begin
      @(posedge i_mclk);
      if (i_awvalid && o_awready) i_awvalid <= 1'h0;
      if (i_wvalid && o_wready) i_wvalid <= 1'h0;
      if (o_bvalid) break;
    end
    i_bready <= 1'h0;
    check_word({30'h0, o_bresp}, {30'h0, er});
  endtask : axi_write

  task axi_read(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge i_mclk);
    i_araddr <= a;
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    forever begin
      @(posedge i_mclk);
      if (i_arvalid && o_arready) i_arvalid <= 1'h0;
      if (o_rvalid) break;
    end
    i_rready <= 1'h0;
    check_word(o_rdata, exp);
    check_word({30'h0, o_rresp}, {30'h0, er});
  endtask : axi_read

  task alu(input size_type sz, input logic [31:0] r, input logic c, input logic v, input logic xl);
    @(posedge i_mclk);
    i_alu <= '{1'h1, sz, r, c, v, xl};
    @(posedge i_mclk);
    i_alu.update <= 1'h0;
  endtask : alu

  task irq(input logic [2:0] lvl, input logic exp);
    @(posedge i_mclk);
    i_irq_level <= lvl;
    repeat (3) @(posedge i_mclk);
    check_bit(o_irq_accept, exp);
  endtask : irq

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    i_rst = 1'h1;
    {i_awaddr, i_araddr, i_wstrb, i_wdata} = '0;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = '0;
    i_irq_level = 3'h0;
    i_alu = '0;
    repeat (5) @(posedge i_mclk);
    i_rst <= 1'h0;
    repeat (2) @(posedge i_mclk);
    axi_read(PSW_OFFSET, 32'h2700, RESP_OKAY);
    check_bit(o_supervisor, 1'h1);
    alu(SIZE_BYTE, 32'h180, 1'h1, 1'h0, 1'h1);
    axi_read(PSW_OFFSET, 32'h2719, RESP_OKAY);
    check_bit(o_carry, 1'h1);
    check_bit(o_extend, 1'h1);
    alu(SIZE_WORD, 32'h10000, 1'h0, 1'h1, 1'h0);
    axi_read(PSW_OFFSET, 32'h2716, RESP_OKAY);
    check_bit(o_carry, 1'h0);
    check_bit(o_extend, 1'h1);
    alu(SIZE_LONG, 32'h80000000, 1'h0, 1'h0, 1'h1);
    axi_read(PSW_OFFSET, 32'h2708, RESP_OKAY);
    // Trace codes and mask levels at supervisor level
    axi_write(PSW_OFFSET, 16'h6715, 4'h3, RESP_OKAY);
    axi_read(PSW_OFFSET, 32'h6715, RESP_OKAY);
    check_bit(o_trace_flow, 1'h1);
    check_bit(o_trace_instr, 1'h0);
    axi_write(PSW_OFFSET, 16'ha31f, 4'h3, RESP_OKAY);
    axi_read(PSW_OFFSET, 32'ha31f, RESP_OKAY);
    check_bit(o_trace_flow, 1'h0);
    check_bit(o_trace_instr, 1'h1);
    irq(3'h3, 1'h0);
    irq(3'h4, 1'h1);
    axi_write(PSW_OFFSET, 16'he700, 4'h2, RESP_OKAY);
    axi_read(PSW_OFFSET, 32'he71f, RESP_OKAY);
    check_bit(o_trace_flow, 1'h0);
    check_bit(o_trace_instr, 1'h0);
    irq(3'h7, 1'h0);
    // Unmapped word answers with an error and changes nothing
    axi_write(4'h4, 16'h1234, 4'h3, RESP_SLVERR);
    axi_read(4'h4, 32'h0, RESP_SLVERR);
    axi_read(PSW_OFFSET, 32'he71f, RESP_OKAY);
    // Drop to user level, then the system byte is out of reach
    axi_write(PSW_OFFSET, 16'h0500, 4'h3, RESP_OKAY);
    axi_read(PSW_OFFSET, 32'h0, RESP_OKAY);
    check_bit(o_supervisor, 1'h0);
    axi_write(PSW_OFFSET, 16'h2713, 4'h3, RESP_OKAY);
    axi_read(PSW_OFFSET, 32'h0013, RESP_OKAY);
    check_bit(o_supervisor, 1'h0);
    irq(3'h6, 1'h1);
    irq(3'h5, 1'h0);
    give_verdict();
  end

endmodule : test_cpu_status_register

`default_nettype wire
